// *** hdl/safety_input_filter_area_monitor.sv ***
`timescale 1ns/1ps
`include "safety_input_map.svh"
module safety_input_filter_area_monitor
#(
  parameter int NUM_DUAL = 8,
  parameter int NUM_ZONE = 3,
  parameter int NUM_POS = 4,
  parameter int TICKS_PER_MS = `CLOCK_KHZ
)
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Safety channels from pins
  input wire safety_input_pkg::dual_mask_type safety_channel_a,
  input wire safety_input_pkg::dual_mask_type safety_channel_b,
  // Monitoring positions, same clock, x/y/z per position
  input wire safety_input_pkg::coord_type pos_x [NUM_POS],
  input wire safety_input_pkg::coord_type pos_y [NUM_POS],
  input wire safety_input_pkg::coord_type pos_z [NUM_POS],
  // Results
  output safety_input_pkg::dual_mask_type dual_enabled,
  output safety_input_pkg::zone_mask_type zone_enabled,
  output logic channel_mismatch_error,
  output logic category_one_safe_stop,
  output logic irq
);
  import safety_input_pkg::*;

  default clocking check_clk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  localparam int MTW = 7;

  // Ms tick; a loose millisecond grid costs at most one ms of slack
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic ms_tick;
  always_comb
  begin
    ms_tick = (tick_cnt == 32'(TICKS_PER_MS - 1));
    next_tick_cnt = ms_tick ? 32'h0 : tick_cnt + 32'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt <= 32'h0;
    else
      tick_cnt <= next_tick_cnt;
  end

  // Registers
  logic [MTW-1:0] filter_ms;
  logic [NUM_ZONE-1:0] zone_en;
  logic [NUM_ZONE-1:0] zone_outside;
  logic [1:0] zone_sel [NUM_ZONE];
  coord_type corner [NUM_ZONE][6];
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] irq_event;
  logic mismatch_any;

  logic wr_en;
  always_comb
    wr_en = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filter_ms <= `FILTER_MS_DEFAULT;
      zone_en <= '0;
      zone_outside <= '0;
      irq_mask <= 2'h0;
      irq_status <= 2'h0;
      for (int z = 0; z < NUM_ZONE; z++)
      begin
        zone_sel[z] <= 2'h0;
        for (int k = 0; k < 6; k++)
          corner[z][k] <= 32'h0;
      end
    end
    else
    begin
      // Set wins over write-one clear
      irq_status <= (irq_status &
        ~((wr_en && paddr == `OFS_IRQ_STATUS) ? pwdata[1:0] : 2'h0))
        | irq_event;
      if (wr_en)
      begin
        if (paddr == `OFS_FILTER_TIME)
          filter_ms <= (pwdata[MTW-1:0] > `FILTER_MS_MAX || |pwdata[31:MTW])
            ? `FILTER_MS_MAX : pwdata[MTW-1:0];
        if (paddr == `OFS_ZONE_CTRL)
        begin
          zone_en <= pwdata[NUM_ZONE-1:0];
          zone_outside <= pwdata[8+NUM_ZONE-1:8];
          for (int z = 0; z < NUM_ZONE; z++)
            zone_sel[z] <= pwdata[16+2*z +: 2];
        end
        if (paddr == `OFS_IRQ_MASK)
          irq_mask <= pwdata[1:0];
        for (int z = 0; z < NUM_ZONE; z++)
          for (int k = 0; k < 6; k++)
            if (paddr == 12'(`OFS_ZONE_BASE + z * `ZONE_STRIDE + k * 4))
              corner[z][k] <= pwdata;
      end
    end
  end

  // Two-flop pin synchronisers
  dual_mask_type sync_a1, sync_a2, sync_b1, sync_b2;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a1 <= '1;
      sync_a2 <= '1;
      sync_b1 <= '1;
      sync_b2 <= '1;
    end
    else
    begin
      sync_a1 <= safety_channel_a;
      sync_a2 <= sync_a1;
      sync_b1 <= safety_channel_b;
      sync_b2 <= sync_b1;
    end
  end

  // Per-channel filters and mismatch timers
  logic [2*NUM_DUAL-1:0] raw_ch;
  logic [2*NUM_DUAL-1:0] filt_ch;
  logic [NUM_DUAL-1:0] mis_hit;
  always_comb
    raw_ch = {sync_b2, sync_a2};

  genvar g;
  generate
    for (g = 0; g < 2*NUM_DUAL; g++)
    begin : g_filt
      logic [MTW-1:0] hold_ms;
      logic [MTW-1:0] next_hold_ms;
      logic filt;
      logic next_filt;
      always_comb
      begin
        next_filt = filt;
        next_hold_ms = hold_ms;
        if (filter_ms == '0 || raw_ch[g] == filt)
        begin
          next_filt = raw_ch[g];
          next_hold_ms = '0;
        end
        else if (ms_tick)
        begin
          if (hold_ms + 7'h1 >= filter_ms)
          begin
            next_filt = raw_ch[g];
            next_hold_ms = '0;
          end
          else
            next_hold_ms = hold_ms + 7'h1;
        end
      end
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          filt <= 1'b1;
          hold_ms <= '0;
        end
        else
        begin
          filt <= next_filt;
          hold_ms <= next_hold_ms;
        end
      end
      assign filt_ch[g] = filt;
    end
    for (g = 0; g < NUM_DUAL; g++)
    begin : g_dual
      logic [MTW-1:0] mis_ms;
      logic [MTW-1:0] next_mis_ms;
      logic hit;
      always_comb
      begin
        hit = 1'b0;
        next_mis_ms = '0;
        if (filt_ch[g] != filt_ch[NUM_DUAL+g])
        begin
          next_mis_ms = mis_ms;
          if (mis_ms >= `MISMATCH_MS)
            hit = 1'b1;
          else if (ms_tick)
            next_mis_ms = mis_ms + 7'h1;
        end
      end
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          mis_ms <= '0;
        else
          mis_ms <= next_mis_ms;
      end
      assign mis_hit[g] = hit;
    end
  endgenerate

  // Zone comparison
  zone_mask_type zone_now;
  logic [NUM_ZONE-1:0] in_box;
  logic [NUM_ZONE-1:0] on_face;
  coord_type pnt;
  coord_type lo;
  coord_type hi;
  always_comb
  begin
    pnt = '0;
    lo = '0;
    hi = '0;
    for (int z = 0; z < NUM_ZONE; z++)
    begin
      // inclusive box from either corner order
      in_box[z] = 1'b1;
      on_face[z] = 1'b0;
      for (int k = 0; k < 3; k++)
      begin
        pnt = (k == 0) ? pos_x[zone_sel[z]] :
            (k == 1) ? pos_y[zone_sel[z]] : pos_z[zone_sel[z]];
        lo = (corner[z][k] < corner[z][k+3]) ? corner[z][k] : corner[z][k+3];
        hi = (corner[z][k] < corner[z][k+3]) ? corner[z][k+3] : corner[z][k];
        if (pnt < lo || pnt > hi)
          in_box[z] = 1'b0;
        if (pnt == lo || pnt == hi)
          on_face[z] = 1'b1;
      end
      // sense, boundary counts for outside too
      zone_now[z] = zone_en[z] && (zone_outside[z]
        ? (!in_box[z] || on_face[z]) : in_box[z]);
    end
  end

  // Outputs registered
  dual_mask_type next_dual;
  always_comb
    for (int n = 0; n < NUM_DUAL; n++)
      // both low enables, both high disables, else hold
      next_dual[n] = (filt_ch[n] == filt_ch[NUM_DUAL+n])
        ? !filt_ch[n] : dual_enabled[n];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dual_enabled <= '0;
      zone_enabled <= '0;
      mismatch_any <= 1'b0;
    end
    else
    begin
      dual_enabled <= next_dual;
      zone_enabled <= zone_now;
      mismatch_any <= |mis_hit;
    end
  end

  // error and stop follow the sticky bit
  always_comb
  begin
    irq_event[`IRQ_BIT_MISMATCH] = mismatch_any;
    irq_event[`IRQ_BIT_ZONE] = zone_now != zone_enabled;
    channel_mismatch_error = irq_status[`IRQ_BIT_MISMATCH];
    category_one_safe_stop = irq_status[`IRQ_BIT_MISMATCH];
    irq = |(irq_status & irq_mask);
    pready = 1'b1;
    pslverr = 1'b0;
  end

  // Read mux, registered at setup
  logic [31:0] next_prdata;
  always_comb
  begin
    next_prdata = 32'h0;
    unique case (paddr)
      `OFS_FILTER_TIME: next_prdata = {25'h0, filter_ms};
      `OFS_ZONE_CTRL: next_prdata = {10'h0, zone_sel[2], zone_sel[1],
        zone_sel[0], 5'h0, zone_outside, 5'h0, zone_en};
      `OFS_STATUS: next_prdata = {mis_hit, 13'h0, zone_enabled,
        dual_enabled};
      `OFS_IRQ_STATUS: next_prdata = {30'h0, irq_status};
      `OFS_IRQ_MASK: next_prdata = {30'h0, irq_mask};
      default:
        for (int z = 0; z < NUM_ZONE; z++)
          for (int k = 0; k < 6; k++)
            if (paddr == 12'(`OFS_ZONE_BASE + z * `ZONE_STRIDE + k * 4))
              next_prdata = corner[z][k];
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable)
      prdata <= next_prdata;
  end

  // Assertions
  a_zone_disabled_off: assert property (
    !zone_en[0] |=> !zone_enabled[0])
    else $error("disabled zone asserted");
  a_filter_max: assert property (
    filter_ms <= `FILTER_MS_MAX)
    else $error("filter time out of range");
  a_stop_with_err: assert property (
    mismatch_any |=> channel_mismatch_error && category_one_safe_stop)
    else $error("mismatch did not stop");
  a_dual_both_low: assert property (
    (!filt_ch[0] && !filt_ch[NUM_DUAL]) |=> dual_enabled[0])
    else $error("dual input not enabled");
  a_filter_zero: assert property (
    filter_ms == '0 |=> filt_ch[0] == $past(raw_ch[0]))
    else $error("zero filter not transparent");
  a_zone_follow: assert property (
    1'b1 |=> zone_enabled == $past(zone_now))
    else $error("zone not re-evaluated");
  a_inside_sense: assert property (
    (zone_en[0] && !zone_outside[0] && in_box[0]) |=> zone_enabled[0])
    else $error("inside zone not asserted");
  a_filter_hold: assert property (
    (filter_ms != '0 && raw_ch[0] != filt_ch[0] && !ms_tick) |=>
      $stable(filt_ch[0]))
    else $error("filter changed early");
endmodule : safety_input_filter_area_monitor

// *** hdl/safety_input_map.svh ***
`ifndef SAFETY_INPUT_MAP_SVH
`define SAFETY_INPUT_MAP_SVH
`define OFS_FILTER_TIME 12'h000
`define OFS_ZONE_CTRL 12'h004
`define OFS_STATUS 12'h008
`define OFS_IRQ_STATUS 12'h00C
`define OFS_IRQ_MASK 12'h010
`define OFS_ZONE_BASE 12'h040
`define ZONE_STRIDE 12'h020
`define FILTER_MS_DEFAULT 7'h0A
`define FILTER_MS_MAX 7'h64
`define MISMATCH_MS 7'h64
`define CLOCK_KHZ 125000
`define IRQ_BIT_MISMATCH 0
`define IRQ_BIT_ZONE 1
`endif

// *** hdl/safety_input_pkg.sv ***
package safety_input_pkg;
  typedef logic [7:0] dual_mask_type;
  typedef logic [2:0] zone_mask_type;
  typedef logic signed [31:0] coord_type;
  typedef logic [15:0] tick_type;
endpackage : safety_input_pkg

// *** tb/safety_far_side_model.sv ***
`timescale 1ns/1ps
module safety_far_side_model
(
  // Switch commands
  input wire logic [7:0] cmd_off,
  input wire logic [7:0] split,
  // Toward the block
  output safety_input_pkg::dual_mask_type safety_channel_a,
  output safety_input_pkg::dual_mask_type safety_channel_b,
  output safety_input_pkg::coord_type pos_x [4],
  output safety_input_pkg::coord_type pos_y [4],
  output safety_input_pkg::coord_type pos_z [4]
);
  import safety_input_pkg::*;
  assign safety_channel_a = ~cmd_off;
  assign safety_channel_b = ~(cmd_off ^ split);
  assign pos_x = '{32'h32, 32'h64, 32'h65, 32'hFFFFFFFB};
  assign pos_y = '{32'h32, 32'h00, 32'h32, 32'hFFFFFFFB};
  assign pos_z = '{32'h32, 32'h64, 32'h32, 32'hFFFFFFFB};
endmodule : safety_far_side_model

// *** tb/safety_input_filter_area_monitor_bench.sv ***
`timescale 1ns/1ps
module safety_input_filter_area_monitor_bench;
  import safety_input_pkg::*;
  typedef struct {logic [31:0] ctrl; zone_mask_type exp;} row_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] cmd_off = 8'h00;
  logic [7:0] split = 8'h00;
  logic [31:0] rd;
  dual_mask_type ch_a;
  dual_mask_type ch_b;
  coord_type px [4];
  coord_type py [4];
  coord_type pz [4];
  dual_mask_type dual_en;
  zone_mask_type zone_en;
  logic mis_err;
  logic stop;
  logic irq;
  int miscompares = 0;
  int total_checks = 0;
  // Rows: zone control word beside expected zone outputs
  row_type rows [4] = '{'{32'h0, 3'h0}, '{32'h00240007, 3'h3},
    '{32'h00240707, 3'h6}, '{32'h00020005, 3'h4}};

  safety_input_filter_area_monitor #(.TICKS_PER_MS(10))
    safety_input_filter_area_monitor_inst
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .safety_channel_a(ch_a),
    .safety_channel_b(ch_b), .pos_x(px), .pos_y(py), .pos_z(pz),
    .dual_enabled(dual_en), .zone_enabled(zone_en),
    .channel_mismatch_error(mis_err), .category_one_safe_stop(stop),
    .irq(irq)
  );

  safety_far_side_model safety_far_side_model_inst
  (
    .cmd_off(cmd_off), .split(split), .safety_channel_a(ch_a),
    .safety_channel_b(ch_b), .pos_x(px), .pos_y(py), .pos_z(pz)
  );

  initial
  begin
    forever #4 pclk = ~pclk;
  end

  task close_out;
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk

  // Request held until pready seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt

  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    close_out;
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wt(2);
    chk("dual_rst", dual_en, 8'h00);
    apb(1'b0, 12'h000, 32'h0);
    chk("filt_rst", rd, 32'h0000000A);
    // Same box in every zone, corners given high then low
    for (int z = 0; z < 3; z++)
      for (int k = 0; k < 6; k++)
        apb(1'b1, 12'h040 + 12'(z * 32 + k * 4), k < 3 ? 32'h64 : 32'h0);
    foreach (rows[i])
    begin
      apb(1'b1, 12'h004, rows[i].ctrl);
      wt(3);
      chk("zone", zone_en, rows[i].exp);
      apb(1'b0, 12'h008, 32'h0);
      chk("zone_stat", rd[10:8], rows[i].exp);
    end
    // Filter 10 ms is 100 cycles here
    @(posedge pclk);
    cmd_off <= 8'h01;
    wt(88);
    chk("filt_early", dual_en, 8'h00);
    wt(32);
    chk("filt_late", dual_en, 8'h01);
    // Chatter shorter than filter time
    @(posedge pclk);
    cmd_off <= 8'h03;
    wt(50);
    @(posedge pclk);
    cmd_off <= 8'h01;
    wt(100);
    chk("chatter", dual_en, 8'h01);
    apb(1'b1, 12'h000, 32'h000000C8);
    apb(1'b0, 12'h000, 32'h0);
    chk("filt_sat", rd, 32'h00000064);
    apb(1'b1, 12'h000, 32'h0);
    cmd_off <= 8'h09;
    wt(15);
    chk("filt_zero", dual_en, 8'h09);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    cmd_off <= 8'h09;
    split <= 8'h04;
    wt(970);
    chk("mis_early", mis_err, 1'b0);
    wt(50);
    chk("mis_err", mis_err, 1'b1);
    chk("safe_stop", stop, 1'b1);
    chk("irq_masked", irq, 1'b0);
    apb(1'b1, 12'h010, 32'h1);
    wt(2);
    chk("irq_on", irq, 1'b1);
    @(posedge pclk);
    split <= 8'h00;
    wt(20);
    apb(1'b1, 12'h00C, 32'h1);
    wt(2);
    chk("irq_clr", irq, 1'b0);
    chk("mis_clr", mis_err, 1'b0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("slverr", pslverr, 1'b0);
    close_out;
  end
endmodule : safety_input_filter_area_monitor_bench
